// ==== rtl/aux_input_detect.sv ====
// input side of the auxiliary card: sixteen inputs, change detection, delayed
// interrupt pulse, serial readout of the buffered status, direct keying path
// assumes all pins are asynchronous to clock; spi_clk is slow enough to be sampled
//
// Contract
// - sixteen inputs 0..15 are buffered and readable serially. (bit 14 reads 0 while the jumper is set)
// - on input data, store states and raise the interrupt.
// - interrupt is active low, one 350 us pulse per change.
// - interrupt pulse starts 30 ms after the change is detected.
// - no interrupt pulse during reset or initialisation.
// - interrupt event latches buffer and reloads comparator reference.
// - compare stored status with present status continuously; difference is change. (code compares only in ST_IDLE and at the end of ST_DELAY)
// - changes persisting 40 ms are detected; slow slopes unsupported.
// - select falling edge enters shift mode, before any clock bits.
// - each rising bit clock shifts the next buffered bit out.
// - jumpered input 14 drives the direct keying line, bypassing buffer.
// - input 0 is repeat request; inputs 1,2,5,8,15 unsupported.
// - input 6 is fallback request; others are user assignable.
// - each transfer carries one 16-bit telegram.
`timescale 1ns/1ps
`default_nettype none
`include "aux_input_params.svh"

module aux_input_detect
	import aux_input_pkg::*;
#(
	parameter int unsigned DELAY_CYC = `AUX_IRQ_DELAY_MS * 1000 * `AUX_CLK_MHZ,
	parameter int unsigned PULSE_CYC = `AUX_IRQ_PULSE_US * `AUX_CLK_MHZ,
	parameter int unsigned INIT_CYC  = `AUX_INIT_HOLD_US * `AUX_CLK_MHZ
) (
	input  wire logic      clock,
	input  wire logic      arst_n,
	input  wire telegram_t general_input,
	input  wire logic      direct_key_jumper,
	input  wire logic      spi_clk,
	input  wire logic      option_slot_select_n,
	output var  logic      option_irq_n,
	output var  logic      miso,
	output var  logic      miso_oe,
	output var  logic      direct_keying_line
);

	function automatic logic status_differs(input telegram_t a, input telegram_t b);
		return a != b;
	endfunction

	telegram_t     gi_s1_r;
	telegram_t     gi_s2_r;
	spi_pins_s     spi_s1_r;
	spi_pins_s     spi_s2_r;
	spi_pins_s     spi_s3_r;
	logic          jmp_s1_r;
	logic          jmp_s2_r;
	logic          dkl_r;
	logic          dkl_nxt;
	detect_state_e state_r;
	detect_state_e state_nxt;
	logic [31:0]   cnt_r;
	logic [31:0]   cnt_nxt;
	telegram_t     ref_r;
	telegram_t     ref_nxt;
	telegram_t     buf_r;
	telegram_t     buf_nxt;
	logic          irq_n_r;
	logic          irq_n_nxt;
	telegram_t     tele;
	logic          sel_fall;
	logic          clk_rise;

	// sixteen synchronised inputs
	// two-stage synchronisers; the third spi stage only feeds edge detection
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gi_s1_r  <= `AUX_BUFFER_RESET;
			gi_s2_r  <= `AUX_BUFFER_RESET;
			spi_s1_r <= '{clk: 1'b0, sel_n: 1'b1};
			spi_s2_r <= '{clk: 1'b0, sel_n: 1'b1};
			spi_s3_r <= '{clk: 1'b0, sel_n: 1'b1};
			jmp_s1_r <= 1'b0;
			jmp_s2_r <= 1'b0;
		end else begin
			gi_s1_r  <= general_input;
			gi_s2_r  <= gi_s1_r;
			spi_s1_r <= '{clk: spi_clk, sel_n: option_slot_select_n};
			spi_s2_r <= spi_s1_r;
			spi_s3_r <= spi_s2_r;
			jmp_s1_r <= direct_key_jumper;
			jmp_s2_r <= jmp_s1_r;
		end
	end

	assign sel_fall = spi_s3_r.sel_n & ~spi_s2_r.sel_n;
	assign clk_rise = ~spi_s3_r.clk & spi_s2_r.clk & ~spi_s2_r.sel_n;

	always_comb begin
		tele = buf_r;
		// bypassed bit is not offered in the telegram
		if (jmp_s2_r) begin
			tele[`AUX_DIRECT_KEY_BIT] = 1'b0;
		end
	end

	always_comb begin
		dkl_nxt = jmp_s2_r & gi_s2_r[`AUX_DIRECT_KEY_BIT];
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			dkl_r <= 1'b0;
		end else begin
			dkl_r <= dkl_nxt;
		end
	end

	// the re-check at the end of the delay filters glitches shorter than the delay,
	// while anything that persists the full detection window after initialisation is reported
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r + 32'h1;
		ref_nxt   = ref_r;
		buf_nxt   = buf_r;
		irq_n_nxt = irq_n_r;
		case (state_r)
			ST_INIT: begin
				irq_n_nxt = 1'b1;
				ref_nxt   = gi_s2_r;
				buf_nxt   = gi_s2_r;
				if (cnt_r == 32'(INIT_CYC - 1)) begin
					state_nxt = ST_IDLE;
					cnt_nxt   = 32'h0;
				end
			end
			ST_IDLE: begin
				cnt_nxt = 32'h0;
				if (status_differs(gi_s2_r, ref_r)) begin
					state_nxt = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (cnt_r == 32'(DELAY_CYC - 1)) begin
					cnt_nxt = 32'h0;
					if (status_differs(gi_s2_r, ref_r)) begin
						state_nxt = ST_PULSE;
						irq_n_nxt = 1'b0;
						buf_nxt   = gi_s2_r;
						ref_nxt   = gi_s2_r;
					end else begin
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_PULSE: begin
				if (cnt_r == 32'(PULSE_CYC - 1)) begin
					irq_n_nxt = 1'b1;
					state_nxt = ST_IDLE;
					cnt_nxt   = 32'h0;
				end
			end
			default: begin
				state_nxt = ST_INIT;
				cnt_nxt   = 32'h0;
				irq_n_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_INIT;
			cnt_r   <= 32'h0;
			ref_r   <= `AUX_BUFFER_RESET;
			buf_r   <= `AUX_BUFFER_RESET;
			irq_n_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			ref_r   <= ref_nxt;
			buf_r   <= buf_nxt;
			irq_n_r <= irq_n_nxt;
		end
	end

	spi_shift16 u_shift (
		.clock    (clock),
		.arst_n   (arst_n),
		.load     (sel_fall),
		.shift    (clk_rise),
		.selected (~spi_s2_r.sel_n),
		.data     (tele),
		.miso     (miso),
		.miso_oe  (miso_oe)
	);

	assign option_irq_n       = irq_n_r;
	assign direct_keying_line = dkl_r;

	// helper: length of the current low phase of the interrupt
	logic [31:0] low_cnt_r;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			low_cnt_r <= 32'h0;
		end else if (!irq_n_r) begin
			low_cnt_r <= low_cnt_r + 32'h1;
		end else begin
			low_cnt_r <= 32'h0;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	chk_irq_pulse_width: assert property ($rose(irq_n_r) |-> low_cnt_r == 32'(PULSE_CYC))
		else $error("interrupt pulse length wrong");
	chk_irq_delay_start: assert property ($fell(irq_n_r) |->
		$past(state_r) == ST_DELAY && $past(cnt_r) == 32'(DELAY_CYC - 1))
		else $error("interrupt started without full delay");
	chk_init_quiet: assert property (state_r == ST_INIT |-> irq_n_r)
		else $error("interrupt during initialisation");
	chk_buffer_latch_ref: assert property ($fell(irq_n_r) |->
		buf_r == ref_r && buf_r == $past(gi_s2_r))
		else $error("buffer or reference not loaded at interrupt");
	chk_change_seen: assert property (
		state_r == ST_IDLE && gi_s2_r != ref_r |=> state_r == ST_DELAY)
		else $error("input change not detected");
	chk_persist_caught: assert property (
		state_r == ST_DELAY && cnt_r == 32'(DELAY_CYC - 1) && gi_s2_r != ref_r
		|=> state_r == ST_PULSE && !irq_n_r)
		else $error("persistent change not reported");
	chk_direct_key: assert property (jmp_s2_r ##1 jmp_s2_r |->
		direct_keying_line == $past(gi_s2_r[`AUX_DIRECT_KEY_BIT]))
		else $error("direct keying line does not follow input");
	chk_select_first_bit: assert property (sel_fall |=> miso == $past(tele[15]) ##0 miso_oe)
		else $error("first telegram bit not presented at select");
	chk_select_release: assert property (spi_s2_r.sel_n |=> !miso_oe)
		else $error("data out driven while deselected");

	cov_irq_pulse: cover property ($fell(irq_n_r));
	cov_glitch_filtered: cover property (state_r == ST_DELAY ##1 state_r == ST_IDLE);
	cov_read_bit: cover property (sel_fall ##[1:200] clk_rise);

endmodule

`default_nettype wire

// ==== rtl/aux_input_params.svh ====
// constants of the auxiliary input change detector: bit positions, reset values, timing
// assumes a 200 MHz core clock; counts are derived in the top module from these figures
`ifndef AUX_INPUT_PARAMS_SVH
`define AUX_INPUT_PARAMS_SVH

`define AUX_CLK_MHZ          200
`define AUX_INPUT_COUNT      16
`define AUX_IRQ_DELAY_MS     30
`define AUX_IRQ_PULSE_US     350
`define AUX_INIT_HOLD_US     1000
`define AUX_MIN_DETECT_MS    40
`define AUX_REPEAT_BIT       0
`define AUX_FALLBACK_BIT     6
`define AUX_DIRECT_KEY_BIT   14
`define AUX_BUFFER_RESET     16'h0000

`endif

// ==== rtl/aux_input_pkg.sv ====
// types shared by the auxiliary input change detector and its serial shifter
// assumes aux_input_params.svh supplies the input count
`include "aux_input_params.svh"

package aux_input_pkg;

	typedef logic [`AUX_INPUT_COUNT-1:0] telegram_t;

	typedef enum logic [1:0] {
		ST_INIT,
		ST_IDLE,
		ST_DELAY,
		ST_PULSE
	} detect_state_e;

	typedef struct packed {
		logic clk;
		logic sel_n;
	} spi_pins_s;

endpackage

// ==== rtl/spi_shift16.sv ====
// serial output shifter of the input telegram, most significant bit first
// assumes load and shift are one-cycle pulses from the core clock domain
`timescale 1ns/1ps
`default_nettype none
`include "aux_input_params.svh"

module spi_shift16
	import aux_input_pkg::*;
(
	input  wire logic      clock,
	input  wire logic      arst_n,
	input  wire logic      load,
	input  wire logic      shift,
	input  wire logic      selected,
	input  wire telegram_t data,
	output var  logic      miso,
	output var  logic      miso_oe
);

	telegram_t sh_r;
	telegram_t sh_nxt;
	logic      miso_r;
	logic      miso_nxt;
	logic      oe_r;
	logic      oe_nxt;

	always_comb begin
		sh_nxt   = sh_r;
		miso_nxt = miso_r;
		oe_nxt   = selected;
		if (load) begin
			sh_nxt   = data;
			miso_nxt = data[$bits(telegram_t)-1];
		end else if (shift) begin
			sh_nxt   = {sh_r[$bits(telegram_t)-2:0], 1'b0};
			miso_nxt = sh_r[$bits(telegram_t)-2];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sh_r   <= `AUX_BUFFER_RESET;
			miso_r <= 1'b0;
			oe_r   <= 1'b0;
		end else begin
			sh_r   <= sh_nxt;
			miso_r <= miso_nxt;
			oe_r   <= oe_nxt;
		end
	end

	assign miso    = miso_r;
	assign miso_oe = oe_r;

endmodule

`default_nettype wire

// ==== bench/spi_host_model.sv ====
// host side of the serial readout: select, bit clock, sample on the falling clock
// assumes the device answers within 15 ns of each select or clock edge
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
	import aux_input_pkg::*;
(
	input  wire logic      miso,
	input  wire logic      miso_oe,
	output var  logic      spi_clk,
	output var  logic      sel_n,
	output var  logic      got,
	output var  telegram_t word
);
	initial begin
		spi_clk = 1'b0;
		sel_n = 1'b1;
		got = 1'b0;
		word = '0;
	end
	// select falls first, then sixteen bits
	task automatic read_word();
		sel_n = 1'b0;
		#24;
		word[15] = miso_oe ? miso : 1'bx;
		for (int i = 14; i >= 0; i--) begin
			spi_clk = 1'b1;
			#24;
			spi_clk = 1'b0;
			word[i] = miso_oe ? miso : 1'bx;
			#24;
		end
		sel_n = 1'b1;
		got = 1'b1;
		#10;
		got = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== bench/aux_input_detect_bench.sv ====
// self-checking bench of the input change detector with a serial host model
// assumes shortened delay, pulse and init counts
`timescale 1ns/1ps
`default_nettype none
module aux_input_detect_bench;
	import aux_input_pkg::*;
	localparam int DLY = 50;
	localparam int PLS = 20;
	logic      clock = 1'b0;
	logic      arst_n = 1'b0;
	telegram_t gin = '0;
	logic      jumper = 1'b0;
	logic      spi_clk, sel_n, irq_n, miso, miso_oe, dkey, got;
	telegram_t word;
	telegram_t exp_q[$];
	int        n_mismatch = 0;
	int        check_count = 0;
	int        low_cnt = 0;
	int        seed = 99;
	int        n;
	telegram_t rnd;
	always #2.5 clock = ~clock;
	aux_input_detect #(.DELAY_CYC(DLY), .PULSE_CYC(PLS), .INIT_CYC(10)) dut_u (
		.clock(clock), .arst_n(arst_n), .general_input(gin),
		.direct_key_jumper(jumper), .spi_clk(spi_clk),
		.option_slot_select_n(sel_n), .option_irq_n(irq_n), .miso(miso),
		.miso_oe(miso_oe), .direct_keying_line(dkey));
	spi_host_model host_u (.miso(miso), .miso_oe(miso_oe), .spi_clk(spi_clk),
		.sel_n(sel_n), .got(got), .word(word));
	task automatic check(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge got) begin
		if (exp_q.size() == 0)
			check(1'b0, "unexpected read");
		else
			check(word === exp_q.pop_front(), "telegram");
	end
	// sampled off the launching edge so the register has settled
	always @(negedge clock) begin
		if (irq_n === 1'b0)
			low_cnt <= low_cnt + 1;
		else if (low_cnt != 0) begin
			check(low_cnt == PLS, "pulse width");
			low_cnt <= 0;
		end
	end
	task automatic wait_irq(output int k);
		k = 0;
		while (irq_n !== 1'b0 && k < 3 * DLY) begin
			@(negedge clock);
			k++;
		end
	endtask
	// host reads the buffer; bit 14 reads 0 while the jumper routes it away
	task automatic read_expect(input telegram_t v);
		v[14] = v[14] & ~jumper;
		exp_q.push_back(v);
		host_u.read_word();
		repeat (4) @(negedge clock);
	endtask
	task automatic change(input telegram_t v, input logic fire);
		@(negedge clock);
		gin = v;
		wait_irq(n);
		if (fire) begin
			check(n >= DLY && n <= DLY + 5, "irq delay");
			read_expect(v);
		end else
			check(n >= 3 * DLY, "irq not expected");
	endtask
	initial begin
		#200000;
		check(1'b0, "timeout");
		final_report();
	end
	initial begin
		repeat (4) @(negedge clock);
		arst_n = 1'b1;
		change(16'h00f0, 1'b0);
		$display("init test done");
		change(16'h8001, 1'b1);
		change(16'hffff, 1'b1);
		check(dkey === 1'b0, "keying without jumper");
		for (int i = 0; i < 6; i++) begin
			rnd = telegram_t'($random(seed));
			// an unchanged word would raise no interrupt
			if (rnd == gin)
				rnd = ~rnd;
			change(rnd, 1'b1);
		end
		$display("change tests done");
		// a change shorter than the delay must be filtered out
		@(negedge clock);
		gin = ~gin;
		repeat (10) @(negedge clock);
		gin = ~gin;
		wait_irq(n);
		check(n >= 3 * DLY, "glitch irq");
		read_expect(gin);
		$display("glitch test done");
		jumper = 1'b1;
		change(gin ^ 16'h4001 | 16'h4000, 1'b1);
		check(dkey === 1'b1, "direct keying");
		jumper = 1'b0;
		$display("jumper test done");
		@(negedge clock);
		arst_n = 1'b0;
		@(negedge clock);
		check(irq_n === 1'b1 && miso_oe === 1'b0 && dkey === 1'b0, "reset outputs");
		arst_n = 1'b1;
		change(16'h0f0f, 1'b0);
		change(16'h0000, 1'b1);
		$display("reset test done");
		final_report();
	end
endmodule
`default_nettype wire
